// ===== hw/mxc_pkg.sv
// Package for the eight-line serial multiplexer control block.
// Assumes a 100 MHz system clock and a word-wide register port.
package mxc_pkg;
    localparam int          CLK_MHZ       = 100;
    localparam int          CLR_PULSE_US  = 15;
    localparam int          CLR_CYCLES    = CLR_PULSE_US * CLK_MHZ;
    localparam logic [10:0] CLR_CNT_LAST  = 11'(CLR_CYCLES - 1);
    // Word indices of the register port (byte offsets 0,2,4,6 divided by two).
    localparam logic [1:0]  A_CSR         = 2'h0;
    localparam logic [1:0]  A_RXBUF       = 2'h1;
    localparam logic [1:0]  A_TXCTL       = 2'h2;
    localparam logic [1:0]  A_MODEM       = 2'h3;
    // Control/status bit positions.
    localparam int          B_LOOP        = 3;
    localparam int          B_CLR         = 4;
    localparam int          B_SCAN        = 5;
    localparam int          B_RIE         = 6;
    localparam int          B_DONE        = 7;
    localparam int          B_LINE_LO     = 8;
    localparam int          B_FALM_MODE   = 12;
    localparam int          B_FALM        = 13;
    localparam int          B_TIE         = 14;
    localparam int          B_TX_LINE_READY        = 15;
    // Receive word fields.
    localparam int          B_VALID       = 15;
    localparam int          B_OVR         = 14;
    localparam int          B_FERR        = 13;
    localparam int          B_PERR        = 12;
    // Interrupt priority.
    localparam logic [2:0]  IRQ_LEVEL     = 3'h5;
    localparam logic [15:0] CSR_RESET     = 16'h0000;
    localparam int          FIFO_DEPTH    = 64;
    localparam int          FIFO_ALARM    = 16;
    localparam int          SCAN_DIV      = 100;
    localparam logic [6:0]  SCAN_DIV_LAST = 7'(SCAN_DIV - 1);
endpackage

// ===== hw/mxc_bus_if.sv
// Carrier between the control block and its receive FIFO.
// Assumes both ends share CLK_SYS.
`timescale 1ns/1ps
interface mxc_bus_if;
    logic        push;
    logic [15:0] push_word;
    logic        pop;
    logic [15:0] head;
    logic        empty;
    logic        full;
    logic [6:0]  count;
    logic        flush;
    modport ctl  (output push, push_word, pop, flush, input head, empty, full, count);
    modport fifo (input push, push_word, pop, flush, output head, empty, full, count);
endinterface

// ===== hw/mxc_rx_fifo.sv
// Receive character FIFO of the multiplexer.
// Assumes the control block never pushes while full or pops while empty.
`timescale 1ns/1ps
module mxc_rx_fifo
    import mxc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Control side.
    mxc_bus_if.fifo  q
);
    typedef struct packed {
        logic [5:0] rd;
        logic [5:0] wr;
        logic [6:0] cnt;
    } mxc_fifo_t;

    mxc_fifo_t   r;
    mxc_fifo_t   next_r;
    logic [15:0] mem [FIFO_DEPTH];

    assign q.head  = mem[r.rd];
    assign q.empty = (r.cnt == 7'h00);
    assign q.full  = (r.cnt == 7'(FIFO_DEPTH));
    assign q.count = r.cnt;

    always_comb begin
        next_r = r;
        if (q.flush) begin
            next_r = '0;
        end else begin
            if (q.push && !q.full) begin
                next_r.wr = r.wr + 6'h01;
            end
            if (q.pop && !q.empty) begin
                next_r.rd = r.rd + 6'h01;
            end
            next_r.cnt = r.cnt + 7'(q.push && !q.full) - 7'(q.pop && !q.empty);
        end
    end

    // Storage has no reset so it can map onto plain RAM.
    always_ff @(posedge CLK_SYS) begin
        if (q.push && !q.full && !q.flush) begin
            mem[r.wr] <= q.push_word;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

// ===== hw/mxc_ctrl.sv
// Control and status logic of an eight-line serial multiplexer.
// Assumes line-side character engines outside drive the per-line strobes.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module mxc_ctrl
    import mxc_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    // Register port.
    input  wire logic [1:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    output logic             ACK,
    // Processor priority.
    input  wire logic [2:0]  CPU_PRIO,
    output logic             IRQ_RX,
    output logic             IRQ_TX,
    // Line side.
    input  wire logic [7:0]  TX_EMPTY,
    input  wire logic [7:0]  RX_AVAIL,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_FERR,
    input  wire logic        RX_PERR,
    output logic      [7:0]  RX_TAKE,
    output logic      [7:0]  TX_LOAD,
    output logic      [7:0]  TX_CHAR,
    output logic      [7:0]  LINE_BREAK,
    output logic      [12:0] PARAM,
    output logic             PARAM_LOAD,
    output logic             LOOPBACK,
    output logic      [7:0]  DTR,
    input  wire logic [7:0]  CARRIER,
    input  wire logic [7:0]  RING
);
    typedef struct packed {
        logic        loop;
        logic        scan;
        logic        falm_mode;
        logic        rx_irq_enable;
        logic        tx_irq_enable;
        logic        done;
        logic        falm;
        logic        tx_line_ready;
        logic [2:0]  tline;
        logic [7:0]  tx_en;
        logic [7:0]  dtr;
        logic [7:0]  line_break_bits;
        logic        clr_busy;
        logic [10:0] clr_cnt;
        logic [2:0]  rx_line;
        logic [6:0]  div;
        logic [15:0] rdata;
        logic        ack;
        logic        irq_rx;
        logic        irq_tx;
        logic [7:0]  rx_take;
        logic [7:0]  tx_load;
        logic [7:0]  tx_char;
        logic [12:0] param;
        logic        param_load;
    } mxc_state_t;

    mxc_state_t r;
    mxc_state_t next_r;
    mxc_bus_if  q ();

    // First line set in mask, counting upward from start and wrapping past line 7.
    function automatic logic [3:0] pick(input logic [7:0] mask, input logic [2:0] start);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            idx = start + 3'(i);
            if (mask[idx]) begin
                res = {1'b0, idx};
            end
        end
        return res;
    endfunction

    logic [15:0] csr_word;
    logic [3:0]  tx_pick;
    logic [3:0]  rx_pick;
    logic        tick;

    mxc_rx_fifo u_fifo (
        .CLK_SYS (CLK_SYS),
        .RSTN    (RSTN),
        .q       (q)
    );

    always_comb begin
        csr_word                        = CSR_RESET;
        csr_word[B_LOOP]                = r.loop;
        csr_word[B_CLR]                 = r.clr_busy;
        csr_word[B_SCAN]                = r.scan;
        csr_word[B_RIE]                 = r.rx_irq_enable;
        csr_word[B_DONE]                = r.done;
        csr_word[B_LINE_LO +: 3]        = r.tline;
        csr_word[B_FALM_MODE]           = r.falm_mode;
        csr_word[B_FALM]                = r.falm;
        csr_word[B_TIE]                 = r.tx_irq_enable;
        csr_word[B_TX_LINE_READY]                = r.tx_line_ready;
    end

    always_comb begin
        next_r            = r;
        next_r.ack        = 1'b0;
        next_r.rx_take    = 8'h00;
        next_r.tx_load    = 8'h00;
        next_r.param_load = 1'b0;
        q.push            = 1'b0;
        q.push_word       = 16'h0000;
        q.pop             = 1'b0;
        q.flush           = 1'b0;
        tick              = (r.div == SCAN_DIV_LAST);
        next_r.div        = tick ? 7'h00 : r.div + 7'h01;
        // A line loaded last cycle still shows empty, so it is masked for that cycle.
        tx_pick           = pick(r.tx_en & TX_EMPTY & ~r.tx_load, r.tline + 3'h1);
        rx_pick           = pick(RX_AVAIL, r.rx_line);

        // Scanner runs only while enabled.
        if (r.scan && !r.clr_busy) begin
            // Ready reports an enabled line with an empty buffer.
            if (!r.tx_line_ready && tx_pick != 4'h8) begin
                next_r.tx_line_ready  = 1'b1;
                next_r.tline = tx_pick[2:0];
            end
            if (tick && rx_pick != 4'h8 && !q.full) begin
                q.push                  = 1'b1;
                q.push_word             = {1'b1, 1'b0, RX_FERR, RX_PERR, 1'b0,
                                           rx_pick[2:0], RX_DATA};
                next_r.rx_take[rx_pick[2:0]] = 1'b1;
                next_r.rx_line          = rx_pick[2:0] + 3'h1;
                // Alarm mode holds off done until the FIFO reaches the threshold.
                if (!r.falm_mode) begin
                    next_r.done = 1'b1;
                end
            end
        end
        // Ready falls once scanning stops or its line is no longer free.
        if (r.tx_line_ready && !(r.scan && r.tx_en[r.tline] && TX_EMPTY[r.tline])) begin
            next_r.tx_line_ready  = 1'b0;
            next_r.tline = 3'h0;
        end
        if (q.count >= 7'(FIFO_ALARM)) begin
            next_r.falm = 1'b1;
            if (r.falm_mode) begin
                next_r.done = 1'b1;
            end
        end

        // Register port; every access is answered next cycle.
        if (WR || RD) begin
            next_r.ack = 1'b1;
        end
        if (RD) begin
            if (ADDR == A_CSR) begin
                next_r.rdata = csr_word;
            end else if (ADDR == A_RXBUF) begin
                // Reading empties one word and re-arms done.
                next_r.rdata = q.empty ? 16'h0000 : q.head;
                q.pop        = !q.empty;
                // Outside alarm mode, a character pushed in this same cycle keeps done set.
                next_r.done  = q.push && !r.falm_mode;
                next_r.falm  = 1'b0;
            end else if (ADDR == A_TXCTL) begin
                next_r.rdata = {r.dtr, r.tx_en};
            end else begin
                next_r.rdata = {CARRIER, RING};
            end
        end
        if (WR) begin
            if (ADDR == A_CSR) begin
                // Only five bits store; status bits ignore writes.
                // A clear written beside them wins, so of the written bits only the clear bit shows set.
                next_r.loop      = WDATA[B_LOOP] && !WDATA[B_CLR];
                next_r.scan      = WDATA[B_SCAN] && !WDATA[B_CLR];
                next_r.falm_mode = WDATA[B_FALM_MODE] && !WDATA[B_CLR];
                next_r.rx_irq_enable       = WDATA[B_RIE] && !WDATA[B_CLR];
                next_r.tx_irq_enable       = WDATA[B_TIE] && !WDATA[B_CLR];
                if (WDATA[B_CLR]) begin
                    next_r.clr_busy = 1'b1;
                    next_r.clr_cnt  = 11'h000;
                end
            end else if (ADDR == A_RXBUF) begin
                // Write-only line parameters, passed straight to the lines.
                next_r.param      = WDATA[12:0];
                next_r.param_load = 1'b1;
            end else if (ADDR == A_TXCTL) begin
                next_r.tx_en = WDATA[7:0];
                next_r.dtr   = WDATA[15:8];
            end else begin
                // Transmit data goes to the line reported ready.
                next_r.line_break_bits     = WDATA[15:8];
                next_r.tx_char = WDATA[7:0];
                if (r.tx_line_ready) begin
                    next_r.tx_load[r.tline] = 1'b1;
                    next_r.tx_line_ready             = 1'b0;
                    next_r.tline            = 3'h0;
                end
            end
        end

        // Pulse length is counted so the bit stays visible while it runs.
        if (r.clr_busy) begin
            next_r.clr_cnt   = r.clr_cnt + 11'h001;
            next_r.loop      = 1'b0;
            next_r.scan      = 1'b0;
            next_r.falm_mode = 1'b0;
            next_r.rx_irq_enable       = 1'b0;
            next_r.tx_irq_enable       = 1'b0;
            next_r.done      = 1'b0;
            next_r.falm      = 1'b0;
            next_r.tx_line_ready      = 1'b0;
            next_r.tline     = 3'h0;
            next_r.tx_en     = 8'h00;
            next_r.line_break_bits       = 8'h00;
            next_r.rx_line   = 3'h0;
            q.flush          = 1'b1;
            q.pop            = 1'b0;
            // DTR latches are deliberately left alone here.
            if (r.clr_cnt == CLR_CNT_LAST) begin
                next_r.clr_busy = 1'b0;
            end
        end

        // Request only when the processor runs below level 5.
        next_r.irq_rx = r.done && r.rx_irq_enable && (CPU_PRIO < IRQ_LEVEL);
        next_r.irq_tx = r.tx_line_ready && r.tx_irq_enable && (CPU_PRIO < IRQ_LEVEL);
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign RDATA      = r.rdata;
    assign ACK        = r.ack;
    assign IRQ_RX     = r.irq_rx;
    assign IRQ_TX     = r.irq_tx;
    assign RX_TAKE    = r.rx_take;
    assign TX_LOAD    = r.tx_load;
    assign TX_CHAR    = r.tx_char;
    assign LINE_BREAK = r.line_break_bits;
    assign PARAM      = r.param;
    assign PARAM_LOAD = r.param_load;
    assign LOOPBACK   = r.loop;
    assign DTR        = r.dtr;
endmodule

// ===== testbench/mxc_ctrl_sva.sv
// Assertion checker for the multiplexer control block, bound to its top.
// Assumes one clock domain and the register port timing of the block.
`timescale 1ns/1ps
module mxc_ctrl_chk
    import mxc_pkg::*;
(
    // Clock and reset.
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    // Register port.
    input wire logic [1:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        ACK,
    // Priority and line side.
    input wire logic [2:0]  CPU_PRIO,
    input wire logic        IRQ_RX,
    input wire logic        IRQ_TX,
    input wire logic [7:0]  TX_LOAD,
    input wire logic [12:0] PARAM,
    input wire logic        PARAM_LOAD,
    input wire logic [7:0]  DTR,
    input wire logic [7:0]  CARRIER,
    input wire logic [7:0]  RING
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    ack_pulse_a: assert property ((WR || RD) |=> ACK)
        else $error("Access was not acknowledged.");
    ack_quiet_a: assert property (!(WR || RD) |=> !ACK)
        else $error("Acknowledge without an access.");
    rdata_hold_a: assert property (!RD |=> $stable(RDATA))
        else $error("Read data changed without a read.");
    modem_read_a: assert property ((RD && ADDR == A_MODEM) |=>
        RDATA == {$past(CARRIER), $past(RING)})
        else $error("Modem status read wrong.");
    dtr_write_a: assert property ((WR && ADDR == A_TXCTL) |=> DTR == $past(WDATA[15:8]))
        else $error("Terminal ready latches not written.");
    param_write_a: assert property ((WR && ADDR == A_RXBUF) |=>
        PARAM_LOAD && PARAM == $past(WDATA[12:0]))
        else $error("Line parameters not loaded.");
    param_quiet_a: assert property (!(WR && ADDR == A_RXBUF) |=> !PARAM_LOAD)
        else $error("Parameter load without a write.");
    prio_block_a: assert property ((CPU_PRIO >= IRQ_LEVEL) |=> !(IRQ_RX || IRQ_TX))
        else $error("Interrupt at or above request level.");
    load_onehot_a: assert property ((TX_LOAD != 8'h00) |-> $onehot(TX_LOAD))
        else $error("More than one line loaded.");
endmodule

bind mxc_ctrl mxc_ctrl_chk i_mxc_ctrl_chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ACK(ACK), .CPU_PRIO(CPU_PRIO), .IRQ_RX(IRQ_RX), .IRQ_TX(IRQ_TX),
    .TX_LOAD(TX_LOAD), .PARAM(PARAM), .PARAM_LOAD(PARAM_LOAD), .DTR(DTR),
    .CARRIER(CARRIER), .RING(RING)
);

// ===== testbench/mxc_line_model.sv
// Line-side model: eight character engines behind the control block.
// Assumes one-hot load and take pulses from the block on the system clock.
`timescale 1ns/1ps
module mxc_line_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Block side.
    input  wire logic [7:0] tx_load,
    input  wire logic [7:0] tx_char,
    input  wire logic [7:0] rx_take,
    output logic      [7:0] tx_empty,
    output logic      [7:0] rx_avail,
    output logic      [7:0] rx_data,
    // Bench side.
    input  wire logic [7:0] rx_req,
    input  wire logic [7:0] busy_len,
    output logic      [7:0] last_load,
    output logic      [7:0] last_char
);
    logic [7:0] busy_cnt;
    logic [7:0] cyc;
    // A loaded line stays busy for busy_len plus one cycles, so a slow engine can be shown.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt  <= 8'h00;
            tx_empty  <= 8'hFF;
            rx_avail  <= 8'h00;
            last_load <= 8'h00;
            last_char <= 8'h00;
            cyc       <= 8'h00;
        end else begin
            cyc      <= cyc + 8'h01;
            rx_avail <= (rx_avail & ~rx_take) | rx_req;
            if (tx_load != 8'h00) begin
                last_load <= tx_load;
                last_char <= tx_char;
                tx_empty  <= tx_empty & ~tx_load;
                busy_cnt  <= busy_len;
            end else if (busy_cnt != 8'h00) begin
                busy_cnt <= busy_cnt - 8'h01;
            end else begin
                tx_empty <= 8'hFF;
            end
        end
    end
    // With nothing offered the data lines wander, so a stale char never looks valid.
    always_comb begin
        rx_data = cyc;
        for (int i = 7; i >= 0; i--) begin
            if (rx_avail[i]) begin
                rx_data = 8'hA0 | 8'(i);
            end
        end
    end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the multiplexer control block.
// Assumes the checker and line model files are compiled before it.
`timescale 1ns/1ps
module tb;
    import mxc_pkg::*;
    logic        clk_sys, rstn, wr, rd, ack, irq_rx, irq_tx, param_load, loopback;
    logic        rx_ferr, rx_perr;
    logic [1:0]  addr;
    logic [2:0]  cpu_prio;
    logic [12:0] param;
    logic [15:0] wdata, rdata, got;
    logic [7:0]  tx_empty, rx_avail, rx_data, rx_take, tx_load, tx_char, line_break, dtr;
    logic [7:0]  rx_req, busy_len, last_load, last_char, carrier, ring;
    int          bad_count = 0, checked = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    mxc_ctrl i_mxc_ctrl (
        .CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ACK(ack), .CPU_PRIO(cpu_prio), .IRQ_RX(irq_rx), .IRQ_TX(irq_tx),
        .TX_EMPTY(tx_empty), .RX_AVAIL(rx_avail), .RX_DATA(rx_data), .RX_FERR(rx_ferr),
        .RX_PERR(rx_perr), .RX_TAKE(rx_take), .TX_LOAD(tx_load), .TX_CHAR(tx_char),
        .LINE_BREAK(line_break), .PARAM(param), .PARAM_LOAD(param_load),
        .LOOPBACK(loopback), .DTR(dtr), .CARRIER(carrier), .RING(ring)
    );
    mxc_line_model i_mxc_line_model (
        .clk(clk_sys), .rst_n(rstn), .tx_load(tx_load), .tx_char(tx_char),
        .rx_take(rx_take), .tx_empty(tx_empty), .rx_avail(rx_avail), .rx_data(rx_data),
        .rx_req(rx_req), .busy_len(busy_len), .last_load(last_load), .last_char(last_char)
    );
    task automatic complete_run();
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // One strobe cycle; answer and read data are taken in the cycle after it.
    task automatic access(input logic w, input logic [1:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        got = rdata;
        chk(16'(ack), 16'h0001, "ack");
    endtask
    task automatic rdx(input logic [1:0] a, input logic [15:0] exp, input string name);
        access(1'b0, a, 16'h0000);
        chk(got, exp, name);
    endtask
    task automatic t_rw();
        access(1'b1, A_CSR, 16'hFFEF);
        chk(16'(loopback), 16'h0001, "loopback");
        rdx(A_CSR, 16'h5068, "csr rw");
        access(1'b1, A_CSR, 16'h0000);
        rdx(A_CSR, 16'h0000, "csr zero");
    endtask
    task automatic t_clear();
        access(1'b1, A_TXCTL, 16'hA55A);
        access(1'b1, A_CSR, 16'h5078);
        rdx(A_CSR, 16'h0010, "clear start");
        idle(1400);
        rdx(A_CSR, 16'h0010, "clear held");
        idle(200);
        rdx(A_CSR, 16'h0000, "clear done");
        rdx(A_TXCTL, 16'hA500, "txctl after clear");
        chk(16'(dtr), 16'h00A5, "dtr pins");
    endtask
    task automatic t_bus_reset();
        access(1'b1, A_TXCTL, 16'hFF00);
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(1);
        rdx(A_TXCTL, 16'h0000, "dtr after reset");
    endtask
    task automatic t_tx();
        access(1'b1, A_TXCTL, 16'h0004);
        rdx(A_CSR, 16'h0000, "ready without scan");
        access(1'b1, A_CSR, 16'h4020);
        idle(4);
        rdx(A_CSR, 16'hC220, "ready line");
        cpu_prio <= 3'h5;
        idle(3);
        chk(16'(irq_tx), 16'h0000, "tx irq at level");
        cpu_prio <= 3'h4;
        idle(3);
        chk(16'(irq_tx), 16'h0001, "tx irq below level");
        access(1'b1, A_MODEM, 16'h0455);
        idle(2);
        chk({last_load, last_char}, 16'h0455, "loaded line and char");
        chk(16'(line_break), 16'h0004, "break");
        rdx(A_CSR, 16'h4020, "ready while busy");
        rdx(A_MODEM, 16'h3CC3, "modem status");
        carrier <= 8'h81;
        ring    <= 8'h7E;
        rdx(A_MODEM, 16'h817E, "modem status moved");
        idle(60);
        rdx(A_CSR, 16'hC220, "ready again");
        access(1'b1, A_CSR, 16'h0000);
        access(1'b1, A_TXCTL, 16'h0000);
    endtask
    task automatic t_rx();
        rx_ferr <= 1'b1;
        rx_req  <= 8'h20;
        access(1'b1, A_CSR, 16'h0060);
        rx_req  <= 8'h00;
        for (int i = 0; i < 300 && irq_rx !== 1'b1; i++) begin
            idle(1);
        end
        chk(16'(irq_rx), 16'h0001, "rx irq");
        rdx(A_CSR, 16'h00E0, "rx done");
        rdx(A_RXBUF, 16'hA5A5, "rx word");
        idle(2);
        chk(16'(irq_rx), 16'h0000, "rx irq after read");
        access(1'b1, A_RXBUF, 16'h1F3D);
        chk(16'(param), 16'h1F3D, "params");
        rdx(A_RXBUF, 16'h0000, "rx empty");
    endtask
    // The ceiling leaves about three times the expected run length.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        {wr, rd, rx_ferr, rx_perr} = 4'h0;
        addr = 2'h0;
        wdata = 16'h0000;
        cpu_prio = 3'h7;
        rx_req = 8'h00;
        carrier = 8'h3C;
        ring = 8'hC3;
        busy_len = 8'h28;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        idle(1);
        t_rw();
        t_clear();
        t_bus_reset();
        t_tx();
        t_rx();
        complete_run();
    end
endmodule
